// ===== hw/slc_control_core.sv
// Control register, ID-bus and select scan stages, condition output logic.
// Assumes TAP strobes, instruction and count come from ref_clk logic;
// ID bus and condition input are pins and are synchronised here.
//
// Operation
// - ID-bus scan selects ID register and captures ID pins at Capture-DR.
// - ID-bus read selects ID register and keeps contents at Capture-DR.
// - Select scan selects select register with no preload at Capture-DR.
// - Control register is ten shift bits, cleared to zero by reset.
// - Shifted control value becomes active only in Update-DR.
// - Bit 9 picks counter direction, 0 up, 1 down, reset up.
// - Bit 8 stops down count at zero; no effect counting up.
// - Bit 7 sets output polarity, 0 active low, reset active low.
// - Bits 6:5 pick output source; inactive drives deasserted level.
// - Count end flag low at zero down or full up; asserts output.
// - Parity source asserts for odd instruction parity from Pause-IR entry to Exit2-IR entry.
// - Bit 4 masks parity source, output stays deasserted.
// - Bit 3 picks drive: 0 open drain, 1 three-state.
// - Bit 2 enables output; disabled floats or shows high.
// - Bit 1 sets input polarity, 0 active low.
// - Input source follows input through both polarity settings.
// - Bit 0 set disables downstream clock, data and mode pins.
// - Parity flag is 1 for even count of ones, 0 for odd.
`timescale 1ns/1ns
`default_nettype none

module slc_control_core (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  // TAP view and scan data
  input  wire slc_pkg::slc_tap_s             tap,
  input  wire logic [slc_pkg::IR_WIDTH-1:0]  instruction,
  input  wire logic                          scanIn,
  output logic                               scanOut,
  output logic                               scanOutEnable,
  // Pins sampled by this block
  input  wire logic [slc_pkg::IDB_WIDTH-1:0] idBusPin,
  input  wire logic                          conditionInputPin,
  // Counter core interface
  input  wire logic [slc_pkg::CNT_WIDTH-1:0] countValue,
  output logic                               countDown,
  output logic                               countOnRising,
  output logic                               counterHold,
  output logic                               countEndN,
  // Condition output pin
  output logic                               conditionOutputOut,
  output logic                               conditionOutputOe,
  // Downstream pins and select register
  output logic                               downstreamPinsEnable,
  output logic [slc_pkg::SEL_WIDTH-1:0]      selectShift
);

  // Pin synchronisers
  logic [slc_pkg::IDB_WIDTH-1:0] idBusMeta;
  logic [slc_pkg::IDB_WIDTH-1:0] idBusSync;
  logic                          condInMeta;
  logic                          condInSync;

  // Decoded strobes
  logic isControl;
  logic isIdScan;
  logic isIdRead;
  logic isSelect;
  logic tapReset;
  logic captureDr;
  logic shiftDr;
  logic updateDr;

  // Scan stages and latched copy
  logic [slc_pkg::CTL_WIDTH-1:0] ctlShift;
  logic [slc_pkg::CTL_WIDTH-1:0] ctlLatched;
  logic [slc_pkg::IDB_WIDTH-1:0] idbValue;
  logic                          ctlSerial;
  logic                          idbSerial;
  logic                          selSerial;
  slc_pkg::slc_ctl_s             cfg;

  // Condition logic
  logic parityFlag;
  logic pauseWindow;
  logic inputActive;
  logic asserted;
  logic level;
  logic next_out;
  logic next_oe;
  logic next_scanOut;

  // Two flops on each pin before any use
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idBusMeta  <= slc_pkg::IDB_RESET;
      idBusSync  <= slc_pkg::IDB_RESET;
      condInMeta <= 1'b0;
      condInSync <= 1'b0;
    end else begin
      idBusMeta  <= idBusPin;
      idBusSync  <= idBusMeta;
      condInMeta <= conditionInputPin;
      condInSync <= condInMeta;
    end
  end

  // Instruction decode
  assign isControl = (instruction == slc_pkg::OP_CONTROL_SCAN_A) ||
                     (instruction == slc_pkg::OP_CONTROL_SCAN_B);
  assign isIdScan  = (instruction == slc_pkg::OP_ID_BUS_SCAN);
  assign isIdRead  = (instruction == slc_pkg::OP_ID_BUS_READ);
  assign isSelect  = (instruction == slc_pkg::OP_SELECT_SCAN);

  // TAP strobes: capture and shift on rising, update on falling
  assign tapReset  = (tap.state == slc_pkg::TAP_RESET);
  assign captureDr = tap.tckRise && (tap.state == slc_pkg::TAP_CAPTURE_DR);
  assign shiftDr   = tap.tckRise && (tap.state == slc_pkg::TAP_SHIFT_DR);
  assign updateDr  = tap.tckFall && (tap.state == slc_pkg::TAP_UPDATE_DR);

  // Control shift stage, never preloaded, cleared in reset
  slc_scan_stage #(
    .WIDTH       (slc_pkg::CTL_WIDTH),
    .RESET_VALUE (slc_pkg::CTL_RESET)
  ) ctlStage (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .clear        (tapReset),
    .capture      (1'b0),
    .captureValue (slc_pkg::CTL_RESET),
    .shift        (shiftDr && isControl),
    .serialIn     (scanIn),
    .value        (ctlShift),
    .serialOut    (ctlSerial)
  );

  // ID-bus stage, not cleared in the TAP reset state
  slc_scan_stage #(
    .WIDTH       (slc_pkg::IDB_WIDTH),
    .RESET_VALUE (slc_pkg::IDB_RESET)
  ) idbStage (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .clear        (1'b0),
    .capture      (captureDr && isIdScan),
    .captureValue (idBusSync),
    .shift        (shiftDr && (isIdScan || isIdRead)),
    .serialIn     (scanIn),
    .value        (idbValue),
    .serialOut    (idbSerial)
  );

  // Select stage, shifted and cleared in reset, never preloaded, decoding lives outside
  slc_scan_stage #(
    .WIDTH       (slc_pkg::SEL_WIDTH),
    .RESET_VALUE (slc_pkg::SEL_RESET)
  ) selStage (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .clear        (tapReset),
    .capture      (1'b0),
    .captureValue (slc_pkg::SEL_RESET),
    .shift        (shiftDr && isSelect),
    .serialIn     (scanIn),
    .value        (selectShift),
    .serialOut    (selSerial)
  );

  // Latched copy follows the shift stage only at Update-DR
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctlLatched <= slc_pkg::CTL_RESET;
    end else if (tapReset) begin
      ctlLatched <= slc_pkg::CTL_RESET;
    end else if (updateDr && isControl) begin
      ctlLatched <= ctlShift;
    end
  end

  assign cfg = slc_pkg::slc_ctl_s'(ctlLatched);

  // Scan output mux, changes on falling test clock
  always_comb begin
    next_scanOut = scanOut;
    if (isControl) begin
      next_scanOut = ctlSerial;
    end else if (isIdScan || isIdRead) begin
      next_scanOut = idbSerial;
    end else if (isSelect) begin
      next_scanOut = selSerial;
    end
  end

  // Scan output register and enable
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scanOut       <= 1'b0;
      scanOutEnable <= 1'b0;
    end else if (tap.tckFall) begin
      scanOut       <= next_scanOut;
      scanOutEnable <= (tap.state == slc_pkg::TAP_SHIFT_DR);
    end
  end

  // Counter configuration and end flag
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      countDown     <= 1'b0;
      countOnRising <= 1'b0;
      counterHold   <= 1'b0;
      countEndN     <= 1'b1;
    end else begin
      countDown     <= cfg.countDown;
      countOnRising <= cfg.inActiveHigh;
      counterHold   <= cfg.countDown && cfg.latchOnZero &&
                       (countValue == slc_pkg::CNT_ZERO);
      countEndN     <= !((cfg.countDown && countValue == slc_pkg::CNT_ZERO) ||
                         (!cfg.countDown && countValue == slc_pkg::CNT_FULL));
    end
  end

  // Even count of ones gives 1
  assign parityFlag = ~^instruction;

  // Window opened entering Pause-IR, closed entering Exit2-IR
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pauseWindow <= 1'b0;
    end else if (tap.tckFall && tap.state == slc_pkg::TAP_PAUSE_IR) begin
      pauseWindow <= 1'b1;
    end else if (tap.tckFall && tap.state == slc_pkg::TAP_EXIT2_IR) begin
      pauseWindow <= 1'b0;
    end else if (tap.tckFall && tap.state != slc_pkg::TAP_PAUSE_IR) begin
      pauseWindow <= 1'b0;
    end
  end

  // Input active when it matches its polarity
  assign inputActive = (condInSync == cfg.inActiveHigh);

  // Source selection into an asserted state
  always_comb begin
    case (cfg.source)
      slc_pkg::SRC_INACTIVE:  asserted = 1'b0;
      slc_pkg::SRC_PARITY:    asserted = !cfg.parityMask &&
                                         !parityFlag &&
                                         pauseWindow;
      slc_pkg::SRC_COUNT_END: asserted = !countEndN;
      slc_pkg::SRC_INPUT:     asserted = inputActive;
      default:                asserted = 1'b0;
    endcase
  end

  // Apply output polarity
  assign level = cfg.outActiveHigh ? asserted : !asserted;

  // Drive type and enable
  always_comb begin
    next_out = 1'b0;
    next_oe  = 1'b0;
    if (!cfg.outEnable) begin
      next_out = 1'b0;
      next_oe  = 1'b0;
    end else if (cfg.threeState) begin
      next_out = level;
      next_oe  = 1'b1;
    end else begin
      next_out = 1'b0;
      next_oe  = !level;
    end
  end

  // Registered pin drive
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conditionOutputOut   <= 1'b0;
      conditionOutputOe    <= 1'b0;
      downstreamPinsEnable <= 1'b1;
    end else begin
      conditionOutputOut   <= next_out;
      conditionOutputOe    <= next_oe;
      downstreamPinsEnable <= !cfg.downstreamDisable;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence enterPause;
    tap.tckFall && tap.state == slc_pkg::TAP_PAUSE_IR;
  endsequence

  sequence maskedHeld;
    (cfg.source == slc_pkg::SRC_PARITY && cfg.parityMask &&
     cfg.outEnable && cfg.threeState) [*2];
  endsequence

  ctl_reset_clear_a: assert property (tapReset |=> ctlLatched == '0)
    else $error("Control copy not cleared in reset state");

  ctl_update_load_a: assert property (
    updateDr && isControl && !tapReset |=> ctlLatched == $past(ctlShift))
    else $error("Control copy missed update");

  ctl_shift_hold_a: assert property (
    !(updateDr && isControl) && !tapReset |=> $stable(ctlLatched))
    else $error("Control copy changed outside update");

  idb_capture_a: assert property (
    captureDr && isIdScan |=> idbValue == $past(idBusSync))
    else $error("ID bus not captured");

  idb_read_hold_a: assert property (
    captureDr && isIdRead |=> $stable(idbValue))
    else $error("ID register changed on read capture");

  sel_no_preload_a: assert property (
    captureDr && isSelect |=> $stable(selectShift))
    else $error("Select register preloaded");

  pause_window_a: assert property (enterPause |=> pauseWindow)
    else $error("Parity window not opened");

  pause_hold_a: assert property (
    pauseWindow && !tap.tckFall |=> pauseWindow)
    else $error("Parity window closed between falling edges");

  pause_close_a: assert property (
    tap.tckFall && tap.state == slc_pkg::TAP_EXIT2_IR |=> !pauseWindow)
    else $error("Parity window still open in Exit2-IR");

  parity_masked_a: assert property (
    maskedHeld |-> conditionOutputOut == !cfg.outActiveHigh && conditionOutputOe)
    else $error("Masked parity reached output");

  count_end_a: assert property (
    !cfg.countDown && countValue == slc_pkg::CNT_FULL ##1 !cfg.countDown
    |-> !countEndN)
    else $error("Count end flag missing");

  downstream_off_a: assert property (
    cfg.downstreamDisable |=> !downstreamPinsEnable)
    else $error("Downstream pins left enabled");

  disabled_float_a: assert property (
    !cfg.outEnable |=> !conditionOutputOe)
    else $error("Disabled output still driven");

endmodule

`default_nettype wire

// ===== hw/slc_pkg.sv
// Shared constants and types for the scan linker control block.
// Assumes the TAP controller and counter core live outside on ref_clk.
package slc_pkg;

  // Register widths
  localparam int CTL_WIDTH = 10;
  localparam int IDB_WIDTH = 4;
  localparam int SEL_WIDTH = 8;
  localparam int IR_WIDTH  = 8;
  localparam int CNT_WIDTH = 8;

  // Values after reset
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 10'h000;
  localparam logic [SEL_WIDTH-1:0] SEL_RESET = 8'h00;
  localparam logic [IDB_WIDTH-1:0] IDB_RESET = 4'h0;

  // Instruction opcodes decoded by this block
  localparam logic [IR_WIDTH-1:0] OP_CONTROL_SCAN_A = 8'h8E;
  localparam logic [IR_WIDTH-1:0] OP_CONTROL_SCAN_B = 8'h0F;
  localparam logic [IR_WIDTH-1:0] OP_ID_BUS_SCAN    = 8'hFC;
  localparam logic [IR_WIDTH-1:0] OP_ID_BUS_READ    = 8'h7D;
  localparam logic [IR_WIDTH-1:0] OP_SELECT_SCAN    = 8'h7E;

  // Counter end values
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_WIDTH-1:0] CNT_FULL = 8'hFF;

  // Condition output source selection
  typedef enum logic [1:0] {
    SRC_INACTIVE,
    SRC_PARITY,
    SRC_COUNT_END,
    SRC_INPUT
  } slc_src_e;

  // TAP controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAPTURE_DR,
    TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPDATE_DR, TAP_SEL_IR, TAP_CAPTURE_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPDATE_IR
  } slc_tap_e;

  // TAP view: test clock edge strobes and current state
  typedef struct packed {
    logic     tckRise;
    logic     tckFall;
    slc_tap_e state;
  } slc_tap_s;

  // Control register layout, bit 9 first down to bit 0
  typedef struct packed {
    logic     countDown;
    logic     latchOnZero;
    logic     outActiveHigh;
    slc_src_e source;
    logic     parityMask;
    logic     threeState;
    logic     outEnable;
    logic     inActiveHigh;
    logic     downstreamDisable;
  } slc_ctl_s;

endpackage

// ===== hw/slc_scan_stage.sv
// Serial scan stage with capture, shift and synchronous clear.
// Assumes capture and shift are one-cycle strobes on ref_clk; clear may be a held level.
`timescale 1ns/1ns
`default_nettype none

module slc_scan_stage #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Controls
  input  wire logic             clear,
  input  wire logic             capture,
  input  wire logic [WIDTH-1:0] captureValue,
  input  wire logic             shift,
  input  wire logic             serialIn,
  // Contents
  output logic      [WIDTH-1:0] value,
  output logic                  serialOut
);

  // Clear wins, then capture, then shift toward bit 0
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      value <= RESET_VALUE;
    end else if (clear) begin
      value <= RESET_VALUE;
    end else if (capture) begin
      value <= captureValue;
    end else if (shift) begin
      value <= {serialIn, value[WIDTH-1:1]};
    end
  end

  // Bit nearest the scan output
  assign serialOut = value[0];

endmodule

`default_nettype wire

// ===== tb/slc_tap_model.sv
// Test bus controller model driving the TAP view of the control core.
// Assumes the core samples strobes on ref_clk and returns data LSB first.
`timescale 1ns/1ns
`default_nettype none

module slc_tap_model (
  // Clock and serial return
  input  wire logic                         ref_clk,
  input  wire logic                         scanOut,
  // TAP drive
  output var  slc_pkg::slc_tap_s            tap,
  output var  logic [slc_pkg::IR_WIDTH-1:0] instruction,
  output var  logic                         scanIn
);
  int          gap = 1;
  logic [15:0] shiftOut;

  // Idle levels at time zero
  initial begin
    tap = '{1'b0, 1'b0, slc_pkg::TAP_IDLE};
    instruction = slc_pkg::OP_CONTROL_SCAN_A;
    scanIn = 1'b0;
    shiftOut = '0;
  end

  // One TCK period: rise acts on the old state, fall on the new one
  task automatic step(input slc_pkg::slc_tap_e nxt, input logic tdi);
    @(posedge ref_clk);
    scanIn <= tdi;
    tap.tckRise <= 1'b1;
    @(posedge ref_clk);
    tap.tckRise <= 1'b0;
    tap.state <= nxt;
    scanIn <= ~tdi; // Data not held past its sample
    repeat (gap) @(posedge ref_clk);
    tap.tckFall <= 1'b1;
    @(posedge ref_clk);
    tap.tckFall <= 1'b0;
    repeat (gap + 1) @(posedge ref_clk);
    if (tap.state == slc_pkg::TAP_SHIFT_DR) begin
      shiftOut = {scanOut, shiftOut[15:1]};
    end
  endtask

  // Data scan; without update it parks in Pause-DR
  task automatic scan_dr(input logic [7:0] op, input logic [15:0] d, input int n,
                         input bit upd, output logic [15:0] rd);
    instruction <= op;
    step(slc_pkg::TAP_SEL_DR, 1'b0);
    step(slc_pkg::TAP_CAPTURE_DR, 1'b0);
    step(slc_pkg::TAP_SHIFT_DR, 1'b0);
    for (int i = 0; i < n - 1; i++) step(slc_pkg::TAP_SHIFT_DR, d[i]);
    step(slc_pkg::TAP_EXIT1_DR, d[n-1]);
    rd = shiftOut >> (16 - n);
    if (upd) begin
      step(slc_pkg::TAP_UPDATE_DR, 1'b0);
      step(slc_pkg::TAP_IDLE, 1'b0);
    end else begin
      step(slc_pkg::TAP_PAUSE_DR, 1'b0);
    end
  endtask

  // Instruction path up to Pause-IR
  task automatic ir_to_pause(input logic [7:0] ir);
    instruction <= ir;
    step(slc_pkg::TAP_SEL_DR, 1'b0);
    step(slc_pkg::TAP_SEL_IR, 1'b0);
    step(slc_pkg::TAP_CAPTURE_IR, 1'b0);
    step(slc_pkg::TAP_SHIFT_IR, 1'b0);
    step(slc_pkg::TAP_EXIT1_IR, 1'b0);
    step(slc_pkg::TAP_PAUSE_IR, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== tb/slc_control_core_tb_top.sv
// Self-checking bench for the scan linker control core.
// Assumes the TAP model carries all scan traffic; pins are driven here.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nErrors++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end

module slc_control_core_tb_top;
  logic              ref_clk, reset, scanIn, scanOut, scanOutEnable, conditionInputPin;
  logic              countDown, countOnRising, counterHold, countEndN, cOut, cOe, dsEn;
  logic [7:0]        instruction, countValue, selectShift;
  logic [3:0]        idBusPin;
  logic [15:0]       rd;
  slc_pkg::slc_tap_s tap;
  int                nErrors = 0;
  int                numChecks = 0;

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  slc_control_core u_slc_control_core (.ref_clk(ref_clk), .reset(reset), .tap(tap),
    .instruction(instruction), .scanIn(scanIn), .scanOut(scanOut),
    .scanOutEnable(scanOutEnable), .idBusPin(idBusPin), .conditionInputPin(conditionInputPin),
    .countValue(countValue), .countDown(countDown), .countOnRising(countOnRising),
    .counterHold(counterHold), .countEndN(countEndN), .conditionOutputOut(cOut),
    .conditionOutputOe(cOe), .downstreamPinsEnable(dsEn), .selectShift(selectShift));

  slc_tap_model u_slc_tap_model (.ref_clk(ref_clk), .scanOut(scanOut), .tap(tap),
    .instruction(instruction), .scanIn(scanIn));

  // Pin drive expected from config and asserted state, as {oe, oe&out}
  function automatic logic [1:0] expPin(slc_pkg::slc_ctl_s c, logic a);
    logic lvl;
    lvl = a ~^ c.outActiveHigh;
    if (!c.outEnable) return 2'b00;
    return c.threeState ? {1'b1, lvl} : {~lvl, 1'b0};
  endfunction

  task automatic check_pin(input string nm, input slc_pkg::slc_ctl_s c, input logic a);
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK(nm, expPin(c, a), {cOe, cOe & cOut})
  endtask

  task automatic set_ctl(input slc_pkg::slc_ctl_s c);
    u_slc_tap_model.scan_dr(slc_pkg::OP_CONTROL_SCAN_A, {6'h00, c}, 10, 1'b1, rd);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic test_reset();
    `CHK("countEndN", 1'b1, countEndN)
    `CHK("dsEn", 1'b1, dsEn)
    `CHK("countDown", 1'b0, countDown)
    check_pin("pin rst", '0, 1'b0);
    u_slc_tap_model.scan_dr(slc_pkg::OP_CONTROL_SCAN_A, 16'h0000, 10, 1'b1, rd);
    `CHK("ctl rst", 16'h0000, rd)
    $display("test reset done");
  endtask

  task automatic test_shadow();
    slc_pkg::slc_ctl_s c;
    c = '0;
    c.countDown = 1'b1;
    c.downstreamDisable = 1'b1;
    u_slc_tap_model.gap = 6;
    u_slc_tap_model.scan_dr(slc_pkg::OP_CONTROL_SCAN_B, {6'h00, c}, 10, 1'b0, rd);
    `CHK("held down", 1'b0, countDown)
    `CHK("held ds", 1'b1, dsEn)
    u_slc_tap_model.step(slc_pkg::TAP_EXIT2_DR, 1'b0);
    u_slc_tap_model.step(slc_pkg::TAP_UPDATE_DR, 1'b0);
    u_slc_tap_model.step(slc_pkg::TAP_IDLE, 1'b0);
    u_slc_tap_model.gap = 1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("upd down", 1'b1, countDown)
    `CHK("upd ds", 1'b0, dsEn)
    c = '0;
    c.inActiveHigh = 1'b1;
    set_ctl(c);
    `CHK("ctl back", 16'h0201, rd)
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("edge sel", 1'b1, countOnRising)
    `CHK("up again", 1'b0, countDown)
    $display("test shadow done");
  endtask

  task automatic test_pins();
    slc_pkg::slc_ctl_s c;
    for (int k = 0; k < 8; k++) begin
      c = '0;
      c.outActiveHigh = k[0];
      c.threeState = k[1];
      c.outEnable = k[2];
      set_ctl(c);
      check_pin("pin idle", c, 1'b0);
    end
    $display("test pins done");
  endtask

  task automatic test_count();
    slc_pkg::slc_ctl_s c;
    logic [11:0] t [5] = '{12'he00, 12'h500, 12'h0ff, 12'h9ff, 12'hd01};
    for (int i = 0; i < 5; i++) begin
      c = '0;
      c.countDown = t[i][11];
      c.latchOnZero = t[i][10];
      c.source = slc_pkg::SRC_COUNT_END;
      c.outActiveHigh = 1'b1;
      c.threeState = 1'b1;
      c.outEnable = 1'b1;
      @(posedge ref_clk);
      countValue <= t[i][7:0];
      set_ctl(c);
      check_pin("pin cnt", c, ~t[i][8]);
      `CHK("countEndN", t[i][8], countEndN)
      `CHK("hold", t[i][9], counterHold)
    end
    $display("test count done");
  endtask

  task automatic test_input();
    slc_pkg::slc_ctl_s c;
    for (int k = 0; k < 8; k++) begin
      c = '0;
      c.source = slc_pkg::SRC_INPUT;
      c.threeState = 1'b1;
      c.outEnable = 1'b1;
      c.inActiveHigh = k[1];
      c.outActiveHigh = k[2];
      @(posedge ref_clk);
      conditionInputPin <= k[0];
      set_ctl(c);
      check_pin("pin input", c, k[0] ~^ k[1]);
    end
    $display("test input done");
  endtask

  task automatic test_parity();
    slc_pkg::slc_ctl_s c;
    logic [9:0] t [4] = '{10'h207, 10'h003, 10'h107, 10'h000};
    for (int i = 0; i < 4; i++) begin
      c = '0;
      c.source = slc_pkg::SRC_PARITY;
      c.parityMask = t[i][8];
      c.threeState = 1'b1;
      c.outEnable = 1'b1;
      set_ctl(c);
      u_slc_tap_model.ir_to_pause(t[i][7:0]);
      check_pin("pin pause", c, t[i][9]);
      u_slc_tap_model.step(slc_pkg::TAP_EXIT2_IR, 1'b0);
      check_pin("pin exit2", c, 1'b0);
      u_slc_tap_model.step(slc_pkg::TAP_UPDATE_IR, 1'b0);
      u_slc_tap_model.step(slc_pkg::TAP_IDLE, 1'b0);
    end
    $display("test parity done");
  endtask

  task automatic test_regs();
    @(posedge ref_clk);
    idBusPin <= 4'ha;
    u_slc_tap_model.scan_dr(slc_pkg::OP_ID_BUS_SCAN, 16'h0003, 4, 1'b1, rd);
    `CHK("id scan", 16'h000a, rd)
    @(posedge ref_clk);
    idBusPin <= 4'h5;
    u_slc_tap_model.scan_dr(slc_pkg::OP_ID_BUS_READ, 16'h0006, 4, 1'b1, rd);
    `CHK("id read", 16'h0003, rd)
    u_slc_tap_model.scan_dr(slc_pkg::OP_SELECT_SCAN, 16'h005c, 8, 1'b1, rd);
    `CHK("sel first", {8'h00, slc_pkg::SEL_RESET}, rd)
    `CHK("sel stage", 8'h5c, selectShift)
    u_slc_tap_model.scan_dr(slc_pkg::OP_SELECT_SCAN, 16'h00a1, 8, 1'b1, rd);
    `CHK("sel again", 16'h005c, rd)
    $display("test regs done");
  endtask

  task automatic test_tap_reset();
    u_slc_tap_model.scan_dr(slc_pkg::OP_SELECT_SCAN, 16'h00c3, 8, 1'b1, rd);
    `CHK("sel prior", 16'h00a1, rd)
    u_slc_tap_model.scan_dr(slc_pkg::OP_CONTROL_SCAN_A, 16'h0003, 10, 1'b0, rd);
    `CHK("oe parked", 1'b0, scanOutEnable)
    u_slc_tap_model.step(slc_pkg::TAP_EXIT2_DR, 1'b0);
    u_slc_tap_model.step(slc_pkg::TAP_SHIFT_DR, 1'b0);
    `CHK("oe shift", 1'b1, scanOutEnable)
    u_slc_tap_model.step(slc_pkg::TAP_EXIT1_DR, 1'b1);
    u_slc_tap_model.step(slc_pkg::TAP_UPDATE_DR, 1'b0);
    u_slc_tap_model.step(slc_pkg::TAP_SEL_DR, 1'b0);
    `CHK("pre down", 1'b1, countDown)
    `CHK("pre ds", 1'b0, dsEn)
    u_slc_tap_model.step(slc_pkg::TAP_SEL_IR, 1'b0);
    u_slc_tap_model.step(slc_pkg::TAP_RESET, 1'b0);
    u_slc_tap_model.step(slc_pkg::TAP_IDLE, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("rst down", 1'b0, countDown)
    `CHK("rst ds", 1'b1, dsEn)
    `CHK("rst sel", 8'h00, selectShift)
    u_slc_tap_model.scan_dr(slc_pkg::OP_CONTROL_SCAN_A, 16'h0000, 10, 1'b1, rd);
    `CHK("rst shift", 16'h0000, rd)
    $display("test tap reset done");
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    idBusPin = 4'h0;
    conditionInputPin = 1'b0;
    countValue = 8'h00;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    test_reset();
    test_shadow();
    test_pins();
    test_count();
    test_input();
    test_parity();
    test_regs();
    test_tap_reset();
    close_out();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    nErrors++;
    close_out();
  end
endmodule
`default_nettype wire
